// ### hdl/hsr_defines.svh
// Constants for the high-speed receive lane interface.
`ifndef HSR_DEFINES_SVH
`define HSR_DEFINES_SVH

// Line states on a lane's two low-power wires, {positive, negative}.
`define HSR_LP_STOP 2'h3
`define HSR_LP_ESC 2'h2
`define HSR_LP_HS 2'h0

// Synchronised pin bundle after reset: both lanes in Stop, clock low.
`define HSR_PINS_RESET 6'h0f

// Leader byte that marks the start of a burst, as it sits LSB first.
`define HSR_SYNC_BYTE 8'hb8

// Core cycles without a received clock edge before the clock counts as lost.
`define HSR_CLK_TIMEOUT 4'h8

// Received clock edges per half period of the byte clock, minus one.
`define HSR_HALF_TC 2'h3

// Last bit index within a byte.
`define HSR_LAST_BIT 3'h7

// Depth of the receive byte buffer.
`define HSR_FIFO_DEPTH 16

`endif

// ### hdl/hsr_pkg.sv
// Types shared by the high-speed receive lane interface.
package hsr_pkg;

	typedef struct packed {
		logic ddr_clk;
		logic hs_data;
		logic [1:0] clk_lp;
		logic [1:0] data_lp;
	} hsr_pins_t;

	typedef enum logic [1:0] {
		CL_STOP,
		CL_ENTRY,
		CL_ULPS,
		CL_OTHER
	} hsr_cl_state_t;

	typedef enum logic [1:0] {
		DL_IDLE,
		DL_HUNT,
		DL_RECV,
		DL_DRAIN
	} hsr_dl_state_t;

endpackage

// ### hdl/hsr_rx_lane.sv
// Receive lane: clock-lane status, deserialiser, byte buffer and byte-clock output stage.
//
// Contract
// - Clock-present output is high while the clock lane receives a DDR clock.
// - Active-low ultra-low-power output goes low when the clock lane enters that state.
// - Ultra-low-power output stays asserted until the clock lane shows Stop.
// - Byte clock is produced by dividing the received DDR clock.
// - Byte clock runs only in high-speed mode; consumer samples only then.
// - Received byte is eight bits, bit 0 being the earliest received.
// - Each received byte is handed over on a rising byte-clock edge.
// - No ready input exists; consumer cannot throttle the received bytes.
// - Reception-active output is high while a high-speed burst is received.
// - Sync output pulses one byte-clock cycle as reception-active first rises.
`timescale 1ns/1ps
`include "hsr_defines.svh"

module hsr_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic flush_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	// Pointers carry one extra wrap bit, so DEPTH must be a power of two.
	localparam int AW = $clog2(DEPTH);
	logic [AW:0] wr_q, wr_d, rd_q, rd_d;
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic full, empty, push, pop;

	always_comb begin
		full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
		empty = (wr_q == rd_q);
		push = in_valid_i && !full;
		pop = out_ready_i && !empty;
		wr_d = flush_i ? '0 : wr_q + {{AW{1'b0}}, push};
		rd_d = flush_i ? '0 : rd_q + {{AW{1'b0}}, pop};
		in_ready_o = !full;
		out_valid_o = !empty;
		out_data_o = mem_q[rd_q[AW-1:0]];
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (push) begin
			mem_q[wr_q[AW-1:0]] <= in_data_i;
		end
	end
endmodule

module hsr_rx_lane #(
	parameter int FIFO_DEPTH = `HSR_FIFO_DEPTH,
	parameter logic [7:0] SYNC_BYTE = `HSR_SYNC_BYTE,
	parameter logic [3:0] CLK_TIMEOUT = `HSR_CLK_TIMEOUT
) (
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic ddr_clk_pin_i,
	input wire logic hs_data_pin_i,
	input wire logic [1:0] clk_lane_lp_i,
	input wire logic [1:0] data_lane_lp_i,
	output logic clock_lane_ddr_clock_present_o,
	output logic clock_lane_low_power_state_n_o,
	output logic rx_byte_clk_o,
	output logic [7:0] rx_data_o,
	output logic rx_valid_o,
	output logic rx_active_o,
	output logic rx_sync_o,
	output logic rx_overflow_o
);
	hsr_pkg::hsr_pins_t pins_raw, meta_q, pins_q;
	logic ddr_prev_q, ddr_edge;
	hsr_pkg::hsr_cl_state_t cl_state_q, cl_state_d;
	logic [3:0] idle_cnt_q, idle_cnt_d;
	logic present_q, present_d, ulps_n_q, ulps_n_d;
	hsr_pkg::hsr_dl_state_t dl_state_q, dl_state_d;
	logic [7:0] shift_q, shift_d, shift_nx, hold_q, hold_d, data_q, data_d;
	logic [2:0] bitcnt_q, bitcnt_d;
	logic [1:0] ecnt_q, ecnt_d;
	logic pend_q, pend_d, ovf_q, ovf_d, seen_q, seen_d, bclk_q, bclk_d;
	logic act_q, act_d, sync_q, sync_d, valid_q, valid_d;
	logic bclk_run, bclk_tick, bfall, flush;
	logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
	logic [7:0] fifo_out_data;

	assign pins_raw = '{ddr_clk: ddr_clk_pin_i, hs_data: hs_data_pin_i,
		clk_lp: clk_lane_lp_i, data_lp: data_lane_lp_i};

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			meta_q <= `HSR_PINS_RESET;
			pins_q <= `HSR_PINS_RESET;
			ddr_prev_q <= 1'b0;
		end else begin
			meta_q <= pins_raw;
			pins_q <= meta_q;
			ddr_prev_q <= pins_q.ddr_clk;
		end
	end

	// Both edges of the received clock carry a bit.
	assign ddr_edge = pins_q.ddr_clk ^ ddr_prev_q;

	always_comb begin
		cl_state_d = cl_state_q;
		idle_cnt_d = idle_cnt_q;
		if (ddr_edge) begin
			idle_cnt_d = '0;
		end else if (idle_cnt_q != CLK_TIMEOUT) begin
			idle_cnt_d = idle_cnt_q + 4'h1;
		end
		present_d = (idle_cnt_d != CLK_TIMEOUT);
		// entry sequence Stop, then 10, then 00
		case (cl_state_q)
			hsr_pkg::CL_STOP: begin
				if (pins_q.clk_lp == `HSR_LP_ESC) begin
					cl_state_d = hsr_pkg::CL_ENTRY;
				end else if (pins_q.clk_lp != `HSR_LP_STOP) begin
					cl_state_d = hsr_pkg::CL_OTHER;
				end
			end
			hsr_pkg::CL_ENTRY: begin
				if (pins_q.clk_lp == `HSR_LP_HS) begin
					cl_state_d = hsr_pkg::CL_ULPS;
				end else if (pins_q.clk_lp == `HSR_LP_STOP) begin
					cl_state_d = hsr_pkg::CL_STOP;
				end else if (pins_q.clk_lp != `HSR_LP_ESC) begin
					cl_state_d = hsr_pkg::CL_OTHER;
				end
			end
			// only Stop leaves the low-power state
			hsr_pkg::CL_ULPS, hsr_pkg::CL_OTHER: begin
				if (pins_q.clk_lp == `HSR_LP_STOP) begin
					cl_state_d = hsr_pkg::CL_STOP;
				end
			end
			default: begin
				cl_state_d = hsr_pkg::CL_STOP;
			end
		endcase
		ulps_n_d = (cl_state_d != hsr_pkg::CL_ULPS);
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cl_state_q <= hsr_pkg::CL_STOP;
			idle_cnt_q <= CLK_TIMEOUT;
			present_q <= 1'b0;
			ulps_n_q <= 1'b1;
		end else begin
			cl_state_q <= cl_state_d;
			idle_cnt_q <= idle_cnt_d;
			present_q <= present_d;
			ulps_n_q <= ulps_n_d;
		end
	end

	always_comb begin
		dl_state_d = dl_state_q;
		shift_d = shift_q;
		bitcnt_d = bitcnt_q;
		hold_d = hold_q;
		ovf_d = ovf_q;
		seen_d = seen_q;
		ecnt_d = ecnt_q;
		bclk_d = bclk_q;
		act_d = act_q;
		sync_d = sync_q;
		valid_d = valid_q;
		data_d = data_q;
		flush = 1'b0;
		fifo_out_ready = 1'b0;
		pend_d = pend_q && !fifo_in_ready;
		// new bits enter at the top, so bit 0 ends up the earliest
		shift_nx = {pins_q.hs_data, shift_q[7:1]};
		// byte clock toggles every four received edges
		bclk_run = present_q && (dl_state_q != hsr_pkg::DL_IDLE);
		bclk_tick = bclk_run && ddr_edge && (ecnt_q == `HSR_HALF_TC);
		bfall = bclk_tick && bclk_q;
		if (bclk_run && ddr_edge) begin
			ecnt_d = ecnt_q + 2'h1;
		end
		if (bclk_tick) begin
			bclk_d = !bclk_q;
		end
		case (dl_state_q)
			hsr_pkg::DL_IDLE: begin
				// byte clock parks low outside high-speed mode
				flush = 1'b1;
				pend_d = 1'b0;
				seen_d = 1'b0;
				act_d = 1'b0;
				sync_d = 1'b0;
				valid_d = 1'b0;
				ecnt_d = '0;
				bclk_d = 1'b0;
				if (pins_q.data_lp == `HSR_LP_HS) begin
					dl_state_d = hsr_pkg::DL_HUNT;
					ovf_d = 1'b0;
					shift_d = '0;
				end
			end
			hsr_pkg::DL_HUNT: begin
				if (pins_q.data_lp == `HSR_LP_STOP) begin
					dl_state_d = hsr_pkg::DL_IDLE;
				end else if (ddr_edge) begin
					shift_d = shift_nx;
					if (shift_nx == SYNC_BYTE) begin
						dl_state_d = hsr_pkg::DL_RECV;
						bitcnt_d = '0;
						seen_d = 1'b1;
					end
				end
			end
			hsr_pkg::DL_RECV: begin
				// dead clock ends reception
				// Without a received clock the byte clock cannot advance, so close at once.
				if (!present_q) begin
					dl_state_d = hsr_pkg::DL_IDLE;
					act_d = 1'b0;
					valid_d = 1'b0;
					sync_d = 1'b0;
				end else if (pins_q.data_lp == `HSR_LP_STOP) begin
					dl_state_d = hsr_pkg::DL_DRAIN;
				end else if (ddr_edge) begin
					shift_d = shift_nx;
					bitcnt_d = bitcnt_q + 3'h1;
					// A byte that finds the buffer still blocked is lost and flagged.
					if (bitcnt_q == `HSR_LAST_BIT) begin
						if (pend_d) begin
							ovf_d = 1'b1;
						end else begin
							pend_d = 1'b1;
							hold_d = shift_nx;
						end
					end
				end
			end
			hsr_pkg::DL_DRAIN: begin
				// A clock that stops before the buffer empties would hang the lane.
				if (!present_q) begin
					dl_state_d = hsr_pkg::DL_IDLE;
					act_d = 1'b0;
					valid_d = 1'b0;
					sync_d = 1'b0;
				end
			end
			default: begin
				dl_state_d = hsr_pkg::DL_IDLE;
			end
		endcase
		// outputs change at the falling edge, so they stand over the rising one
		if (bfall) begin
			// sync pulse spans exactly one byte-clock period
			sync_d = 1'b0;
			if (seen_q && !act_q) begin
				act_d = 1'b1;
				sync_d = 1'b1;
				seen_d = 1'b0;
			end
			// bytes leave whenever present; the consumer has no way to hold them
			fifo_out_ready = act_d;
			valid_d = act_d && fifo_out_valid;
			if (valid_d) begin
				data_d = fifo_out_data;
			end
			// active ends once the burst has ended and every byte is out
			if ((dl_state_q == hsr_pkg::DL_DRAIN) && !pend_q && !fifo_out_valid) begin
				act_d = 1'b0;
				valid_d = 1'b0;
				sync_d = 1'b0;
				dl_state_d = hsr_pkg::DL_IDLE;
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			dl_state_q <= hsr_pkg::DL_IDLE;
			shift_q <= '0;
			bitcnt_q <= '0;
			hold_q <= '0;
			pend_q <= 1'b0;
			ovf_q <= 1'b0;
			seen_q <= 1'b0;
			ecnt_q <= '0;
			bclk_q <= 1'b0;
			act_q <= 1'b0;
			sync_q <= 1'b0;
			valid_q <= 1'b0;
			data_q <= '0;
		end else begin
			dl_state_q <= dl_state_d;
			shift_q <= shift_d;
			bitcnt_q <= bitcnt_d;
			hold_q <= hold_d;
			pend_q <= pend_d;
			ovf_q <= ovf_d;
			seen_q <= seen_d;
			ecnt_q <= ecnt_d;
			bclk_q <= bclk_d;
			act_q <= act_d;
			sync_q <= sync_d;
			valid_q <= valid_d;
			data_q <= data_d;
		end
	end

	hsr_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.core_clk_i(core_clk_i),
		.reset_n_i(reset_n_i),
		.flush_i(flush),
		.in_valid_i(pend_q),
		.in_ready_o(fifo_in_ready),
		.in_data_i(hold_q),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(fifo_out_ready),
		.out_data_o(fifo_out_data)
	);

	assign clock_lane_ddr_clock_present_o = present_q;
	assign clock_lane_low_power_state_n_o = ulps_n_q;
	assign rx_byte_clk_o = bclk_q;
	assign rx_data_o = data_q;
	assign rx_valid_o = valid_q;
	assign rx_active_o = act_q;
	assign rx_sync_o = sync_q;
	assign rx_overflow_o = ovf_q;

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!reset_n_i);

	a_clk_present_edge: assert property (ddr_edge |=> present_q)
		else $error("clock present not set after a received edge");
	a_ulps_entry_low: assert property ((cl_state_q == hsr_pkg::CL_ENTRY
		&& pins_q.clk_lp == `HSR_LP_HS) |=> !ulps_n_q)
		else $error("low-power indicator not asserted on entry");
	a_ulps_hold_stop: assert property ((!ulps_n_q && pins_q.clk_lp != `HSR_LP_STOP)
		|=> !ulps_n_q)
		else $error("low-power indicator released without Stop");
	a_bclk_from_edge: assert property ($changed(bclk_q) |-> $past(ddr_edge)
		|| $past(dl_state_q) == hsr_pkg::DL_IDLE)
		else $error("byte clock moved without a received edge");
	a_bclk_idle_low: assert property ((dl_state_q == hsr_pkg::DL_IDLE) |=> !bclk_q)
		else $error("byte clock running outside high-speed mode");
	a_lsb_first_order: assert property ((dl_state_q == hsr_pkg::DL_RECV && ddr_edge
		&& pins_q.data_lp != `HSR_LP_STOP && bitcnt_q == `HSR_LAST_BIT && !pend_d)
		|=> hold_q[7] == $past(pins_q.hs_data))
		else $error("last received bit not in byte bit 7");
	a_data_stable_rise: assert property (!bfall |=> $stable(data_q))
		else $error("byte changed away from a byte-clock falling edge");
	a_valid_needs_active: assert property (valid_q |-> act_q)
		else $error("valid without reception active");
	a_active_in_burst: assert property (act_q |-> dl_state_q != hsr_pkg::DL_IDLE)
		else $error("reception active while lane idle");
	a_sync_on_rise: assert property ($rose(act_q) |-> sync_q)
		else $error("no sync pulse when active rose");
	a_sync_one_cycle: assert property ((sync_q && bfall) |=> !sync_q)
		else $error("sync pulse longer than one byte clock");

	c_ulps_entered: cover property ($fell(ulps_n_q));
	c_sync_seen: cover property ($rose(sync_q));
	c_byte_delivered: cover property (valid_q && bfall);
	c_overflow_hit: cover property ($rose(ovf_q));
endmodule

// ### verification/hsr_consumer.sv
// Protocol-side consumer model that collects the received lane bytes.
`timescale 1ns/1ps
module hsr_consumer (
	input wire logic rx_byte_clk_i,
	input wire logic [7:0] rx_data_i,
	input wire logic rx_valid_i,
	input wire logic rx_active_i,
	input wire logic rx_sync_i
);
	logic [7:0] got [$];
	int sync_cnt = 0;
	int bad_cnt = 0;

	// sample only on byte clock, never throttle.
	always @(posedge rx_byte_clk_i) begin
		if (rx_valid_i === 1'b1) begin
			got.push_back(rx_data_i);
		end
		if (rx_sync_i === 1'b1) begin
			sync_cnt++;
		end
		if ((rx_sync_i | rx_valid_i) === 1'b1 && rx_active_i !== 1'b1) begin
			bad_cnt++;
		end
	end
endmodule

// ### verification/tb.sv
// Self-checking bench: link driver on the pins, consumer model on the byte side.
`timescale 1ns/1ps
`include "hsr_defines.svh"
module tb;
	logic core_clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic ddr_clk = 1'b0;
	logic hs_data = 1'b0;
	logic [1:0] clk_lp = 2'h3;
	logic [1:0] data_lp = 2'h3;
	logic present;
	logic lp_n;
	logic byte_clk;
	logic valid;
	logic active;
	logic sync;
	logic ovf;
	logic [7:0] data;
	int err_count = 0;
	int compares = 0;

	always #50 core_clk_i = ~core_clk_i;

	hsr_rx_lane i_dut (
		.core_clk_i(core_clk_i),
		.reset_n_i(reset_n_i),
		.ddr_clk_pin_i(ddr_clk),
		.hs_data_pin_i(hs_data),
		.clk_lane_lp_i(clk_lp),
		.data_lane_lp_i(data_lp),
		.clock_lane_ddr_clock_present_o(present),
		.clock_lane_low_power_state_n_o(lp_n),
		.rx_byte_clk_o(byte_clk),
		.rx_data_o(data),
		.rx_valid_o(valid),
		.rx_active_o(active),
		.rx_sync_o(sync),
		.rx_overflow_o(ovf)
	);

	hsr_consumer i_cons (
		.rx_byte_clk_i(byte_clk),
		.rx_data_i(data),
		.rx_valid_i(valid),
		.rx_active_i(active),
		.rx_sync_i(sync)
	);

	task automatic give_verdict();
		$display("counts: %0d compares, %0d mismatches", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
		compares++;
		if (exp !== seen) begin
			err_count++;
			$display("mismatch %s expected %0h seen %0h", name, exp, seen);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk_i);
	endtask

	// Data settles two cycles before the clock edge, so the sync stages see it first.
	task automatic send_bit(input logic b);
		hs_data = b;
		cyc(2);
		ddr_clk = ~ddr_clk;
		cyc(4);
	endtask

	// earliest bit on the wire is bit 0.
	task automatic send_byte(input logic [7:0] v);
		for (int i = 0; i < 8; i++) begin
			send_bit(v[i]);
		end
	endtask

	task automatic t_reset();
		chk("reset low_power_n", 1'b1, lp_n);
		chk("reset present", 1'b0, present);
		chk("reset active", 1'b0, active);
		chk("reset valid", 1'b0, valid);
		chk("reset sync", 1'b0, sync);
		chk("reset byte clock", 1'b0, byte_clk);
		$display("test reset done");
	endtask

	task automatic t_ulps();
		// An entry that returns to Stop before 00 must not reach ultra-low power.
		clk_lp = 2'h2;
		cyc(5);
		clk_lp = 2'h3;
		cyc(5);
		chk("low_power_n aborted entry", 1'b1, lp_n);
		clk_lp = 2'h2;
		cyc(5);
		clk_lp = 2'h0;
		cyc(8);
		chk("low_power_n entered", 1'b0, lp_n);
		chk("present no clock", 1'b0, present);
		clk_lp = 2'h1;
		cyc(8);
		chk("low_power_n held", 1'b0, lp_n);
		clk_lp = 2'h3;
		cyc(5);
		chk("low_power_n exit", 1'b1, lp_n);
		$display("test ulps done");
	endtask

	task automatic t_burst(input logic [31:0] w);
		int n;
		int k;
		i_cons.got.delete();
		n = i_cons.sync_cnt;
		// A high-speed request on the clock lane must not look like ultra-low power.
		clk_lp = 2'h1;
		cyc(4);
		clk_lp = 2'h0;
		data_lp = 2'h0;
		cyc(4);
		send_byte(`HSR_SYNC_BYTE);
		for (int i = 0; i < 4; i++) begin
			send_byte(w[8*i +: 8]);
		end
		chk("present in burst", 1'b1, present);
		chk("active in burst", 1'b1, active);
		data_lp = 2'h3;
		k = 0;
		while (active !== 1'b0) begin
			send_bit(~hs_data);
			k++;
			if (k == 64) begin
				err_count++;
				$display("mismatch active drop expected 0 seen 1");
				give_verdict();
			end
		end
		chk("valid after end", 1'b0, valid);
		chk("byte count", 32'h4, i_cons.got.size());
		for (int i = 0; i < 4 && i < i_cons.got.size(); i++) begin
			chk("byte value", w[8*i +: 8], i_cons.got[i]);
		end
		chk("sync pulses", n + 1, i_cons.sync_cnt);
		chk("flags outside burst", 32'h0, i_cons.bad_cnt);
		chk("overflow", 1'b0, ovf);
		chk("low_power_n on hs request", 1'b1, lp_n);
		hs_data = ~hs_data;
		cyc(16);
		chk("present after stop", 1'b0, present);
		chk("byte clock parked", 1'b0, byte_clk);
		clk_lp = 2'h3;
		cyc(4);
		$display("test burst %0h done", w);
	endtask

	// Received clock dies mid-byte: the burst must be closed without it.
	task automatic t_abort();
		data_lp = 2'h0;
		cyc(4);
		send_byte(`HSR_SYNC_BYTE);
		send_byte(8'h3c);
		for (int i = 0; i < 4; i++) begin
			send_bit(i[0]);
		end
		chk("active before abort", 1'b1, active);
		cyc(20);
		chk("present on abort", 1'b0, present);
		chk("active on abort", 1'b0, active);
		chk("valid on abort", 1'b0, valid);
		chk("byte clock on abort", 1'b0, byte_clk);
		data_lp = 2'h3;
		cyc(8);
		$display("test abort done");
	endtask

	initial begin
		repeat (4) @(negedge core_clk_i);
		reset_n_i = 1'b1;
		cyc(4);
		t_reset();
		t_ulps();
		t_burst(32'hc35a8001);
		t_abort();
		t_burst(32'h7eb8ff00);
		give_verdict();
	end
endmodule
